// ### rtl/rsi_top.sv
`include "rsi_regs.svh"
// ==========================================================
// Summary of operation
// - Power-on clears time-out and power-down flags.
// - Low-voltage reset keeps both flags unchanged.
// - Running watchdog reset sets time-out, keeps power-down.
// - Sleeping watchdog reset sets both flags.
// - Power-on disables all interrupt enables.
// - Power-on clears watchdog counter; it then counts.
// - Power-on zeroes timer control and counter.
// - Power-on loads ones into port data, direction.
// - Power-on sets stack pointer to stack top.
// - Non-sleep resets load defaults; sleep keeps most.
// - Unimplemented bits hold no state.
// - Preserved bits keep their pre-reset value.
// - Low-voltage reset sets flag; software clears it.
// - Sleeping watchdog reset zeroes counter and stack pointer.
module rsi_top #(
	parameter int SP_W = 3, // Stack pointer width.
	parameter int WDT_W = 8 // Watchdog counter width.
) (
	input wire logic pclk, // System clock, 125 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire rsi_pkg::rsi_src_s src, // Reset sources.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped addresses.
	output logic irq, // Level interrupt.
	output rsi_pkg::rsi_flags_s flags, // Status reset flags.
	output logic [7:0] program_counter_low, // Program counter low byte.
	output logic [SP_W-1:0] sp, // Stack pointer.
	output logic [7:0] int_en, // Interrupt enables.
	output logic [7:0] tmr_ctrl, // Timer control.
	output logic [7:0] tmr_cnt, // Timer counter.
	output logic [7:0] port_a, // Port A data.
	output logic [7:0] port_a_dir, // Port A direction, 1 is input.
	output logic [6:0] port_b, // Port B data, seven bits.
	output logic [6:0] port_b_dir, // Port B direction, 1 is input.
	output logic [7:0] time_base_control, // Time-base control.
	output logic [WDT_W-1:0] wdt_cnt // Watchdog counter.
);
	import rsi_pkg::*;

	// Wider values would not fit the eight-bit write path or the read word.
	if (SP_W < 1 || SP_W > 8 || WDT_W < 1 || WDT_W > 32) begin : g_bad_param
		$error("rsi_top: unsupported parameter value");
	end

	// ==========================================================
	// Reset classification.
	rsi_class_e cls; // Class of the reset taken this cycle.
	logic [3:0] ev_now; // One-hot event of this cycle.

	// Coinciding sources are resolved by fixed priority.
	always_comb begin
		if (src.por) begin
			cls = RSI_CL_POR;
		end else if (src.low_voltage_reset) begin
			cls = RSI_CL_LVR;
		end else if (src.wdt) begin
			// The sleep level sampled with the time-out picks the class.
			cls = src.sleep ? RSI_CL_WDS : RSI_CL_WDR;
		end else begin
			cls = RSI_CL_NONE;
		end
	end

	// Defaults apply for every class but the sleeping time-out.
	logic load_def; // Load listed default values.
	assign load_def = (cls == RSI_CL_POR) || (cls == RSI_CL_LVR) || (cls == RSI_CL_WDR);

	always_comb begin
		ev_now = 4'h0;
		case (cls)
			RSI_CL_POR: ev_now[`RSI_EV_POR] = 1'b1;
			RSI_CL_LVR: ev_now[`RSI_EV_LVR] = 1'b1;
			RSI_CL_WDR: ev_now[`RSI_EV_WDR] = 1'b1;
			RSI_CL_WDS: ev_now[`RSI_EV_WDS] = 1'b1;
			default: ev_now = 4'h0;
		endcase
	end

	// ==========================================================
	// APB slave: one wait state, so the answer comes one cycle into access.
	logic acc; // Transfer completes at this edge.
	logic wr; // Completing write.
	logic mapped; // Address hits a register.
	logic [7:0] wd; // Low byte of write data.
	logic [31:0] rd_next; // Read data for the addressed register.
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite && mapped;
	assign wd = pwdata[7:0];

	logic [3:0] evt_reg; // Sticky event status.
	logic [3:0] mask_reg; // Interrupt mask, 1 enables.
	logic low_voltage_reset_flag_reg; // Low-voltage reset flag.

	always_comb begin
		mapped = 1'b1;
		rd_next = 32'h0;
		case (paddr)
			`RSI_OFS_FLAGS: rd_next[1:0] = {flags.powerdown_flag, flags.timeout_flag};
			`RSI_OFS_CTRL: rd_next[`RSI_BIT_LV_FLAG] = low_voltage_reset_flag_reg;
			`RSI_OFS_EVT: rd_next[3:0] = evt_reg;
			`RSI_OFS_MASK: rd_next[3:0] = mask_reg;
			`RSI_OFS_PC_LOW: rd_next[7:0] = program_counter_low;
			`RSI_OFS_SP: rd_next[SP_W-1:0] = sp;
			`RSI_OFS_INTEN: rd_next[7:0] = int_en;
			`RSI_OFS_TMRC: rd_next[7:0] = tmr_ctrl;
			`RSI_OFS_TMRCNT: rd_next[7:0] = tmr_cnt;
			`RSI_OFS_PA: rd_next[7:0] = port_a;
			`RSI_OFS_PAC: rd_next[7:0] = port_a_dir;
			// Bit 7 of port B is not built and reads zero.
			`RSI_OFS_PB: rd_next[6:0] = port_b;
			`RSI_OFS_PBC: rd_next[6:0] = port_b_dir;
			`RSI_OFS_TB_CTRL: rd_next[7:0] = time_base_control;
			`RSI_OFS_WDT: rd_next[WDT_W-1:0] = wdt_cnt;
			default: mapped = 1'b0;
		endcase
	end

	// Ready rises one cycle into the access phase and drops after the hand-off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata <= (psel && penable && !pready && !pwrite) ? rd_next : 32'h0;
		end
	end

	// ==========================================================
	// Status flags: only a reset moves them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
		end else begin
			case (cls)
				RSI_CL_POR: flags <= '0;
				RSI_CL_LVR: flags <= flags;
				RSI_CL_WDR: flags.timeout_flag <= 1'b1;
				RSI_CL_WDS: flags <= 2'b11;
				default: flags <= flags;
			endcase
		end
	end

	// Low-voltage flag: a write of zero clears it, but a low-voltage reset in the
	// same cycle wins so the event is never lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_voltage_reset_flag_reg <= 1'b0;
		end else if (cls == RSI_CL_LVR) begin
			low_voltage_reset_flag_reg <= 1'b1;
		end else if (wr && paddr == `RSI_OFS_CTRL && !wd[`RSI_BIT_LV_FLAG]) begin
			low_voltage_reset_flag_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Interrupt: sticky events, write one to clear, set beats clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_reg <= 4'h0;
			mask_reg <= 4'h0;
		end else begin
			if (wr && paddr == `RSI_OFS_EVT) begin
				evt_reg <= (evt_reg & ~wd[3:0]) | ev_now;
			end else begin
				evt_reg <= evt_reg | ev_now;
			end
			if (wr && paddr == `RSI_OFS_MASK) begin
				mask_reg <= wd[3:0];
			end
		end
	end

	// Registered from next state so the output is a flop yet not late.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (wr && paddr == `RSI_OFS_EVT) begin
			irq <= |(((evt_reg & ~wd[3:0]) | ev_now) & mask_reg);
		end else if (wr && paddr == `RSI_OFS_MASK) begin
			irq <= |((evt_reg | ev_now) & wd[3:0]);
		end else begin
			irq <= |((evt_reg | ev_now) & mask_reg);
		end
	end

	// ==========================================================
	// Core state. Any reset beats a software write in the same cycle.
	// Program counter low byte is cleared by every class.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_counter_low <= `RSI_DEF_ZERO;
		end else if (cls != RSI_CL_NONE) begin
			program_counter_low <= `RSI_DEF_ZERO;
		end else if (wr && paddr == `RSI_OFS_PC_LOW) begin
			program_counter_low <= wd;
		end
	end

	// Stack pointer: top after a defaulting reset, zero after a sleep time-out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp <= '1;
		end else if (load_def) begin
			sp <= '1;
		end else if (cls == RSI_CL_WDS) begin
			sp <= '0;
		end else if (wr && paddr == `RSI_OFS_SP) begin
			sp <= wd[SP_W-1:0];
		end
	end

	// Watchdog counter runs free; every reset class restarts it at zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_cnt <= '0;
		end else if (cls != RSI_CL_NONE) begin
			wdt_cnt <= '0;
		end else begin
			wdt_cnt <= wdt_cnt + 1'b1;
		end
	end

	// Peripheral registers: defaults on a defaulting reset, else held
	// through a sleeping time-out, else software-written.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_en <= `RSI_DEF_ZERO;
			tmr_ctrl <= `RSI_DEF_ZERO;
			tmr_cnt <= `RSI_DEF_ZERO;
			port_a <= `RSI_DEF_ONES;
			port_a_dir <= `RSI_DEF_ONES;
			port_b <= `RSI_DEF_PB;
			port_b_dir <= `RSI_DEF_PB;
		end else if (load_def) begin
			int_en <= `RSI_DEF_ZERO;
			tmr_ctrl <= `RSI_DEF_ZERO;
			tmr_cnt <= `RSI_DEF_ZERO;
			port_a <= `RSI_DEF_ONES;
			port_a_dir <= `RSI_DEF_ONES;
			port_b <= `RSI_DEF_PB;
			port_b_dir <= `RSI_DEF_PB;
		end else if (cls == RSI_CL_WDS) begin
			int_en <= int_en;
		end else if (wr) begin
			case (paddr)
				`RSI_OFS_INTEN: int_en <= wd;
				`RSI_OFS_TMRC: tmr_ctrl <= wd;
				`RSI_OFS_TMRCNT: tmr_cnt <= wd;
				`RSI_OFS_PA: port_a <= wd;
				`RSI_OFS_PAC: port_a_dir <= wd;
				`RSI_OFS_PB: port_b <= wd[6:0];
				`RSI_OFS_PBC: port_b_dir <= wd[6:0];
				default: int_en <= int_en;
			endcase
		end
	end

	// Time-base control reloads on every class, sleep included.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_base_control <= `RSI_DEF_TB_CTRL;
		end else if (cls != RSI_CL_NONE) begin
			time_base_control <= `RSI_DEF_TB_CTRL;
		end else if (wr && paddr == `RSI_OFS_TB_CTRL) begin
			time_base_control <= wd;
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_por_flags_clr: assert property (src.por |=> flags == 2'b00)
		else $error("flags not cleared by power-on");
	a_lvr_flags_keep: assert property (cls == RSI_CL_LVR |=> $stable(flags))
		else $error("flags changed by low-voltage reset");
	a_wdr_flags_set: assert property (cls == RSI_CL_WDR |=> flags.timeout_flag
		&& flags.powerdown_flag == $past(flags.powerdown_flag))
		else $error("running time-out flags wrong");
	a_wds_flags_set: assert property (src.wdt && src.sleep && !src.por && !src.low_voltage_reset
		|=> flags == 2'b11)
		else $error("sleep time-out flags wrong");
	a_por_int_off: assert property (src.por |=> int_en == 8'h00)
		else $error("interrupts left enabled");
	a_wdt_counts: assert property (src.por ##1 !src.por && !src.low_voltage_reset && !src.wdt
		|=> wdt_cnt == 1)
		else $error("watchdog not counting");
	a_por_timer_off: assert property (src.por |=> tmr_ctrl == 8'h00 && tmr_cnt == 8'h00)
		else $error("timer not off");
	a_por_ports_in: assert property (src.por |=> &port_a_dir && &port_a && &port_b_dir)
		else $error("ports not inputs");
	a_por_sp_top: assert property (src.por |=> &sp)
		else $error("stack pointer not at top");
	a_wds_keep: assert property (cls == RSI_CL_WDS
		|=> $stable(port_a_dir) && $stable(int_en)
		&& time_base_control == 8'h37 && program_counter_low == 8'h00)
		else $error("sleep time-out lost state");
	a_lvr_flag_set: assert property (cls == RSI_CL_LVR |=> low_voltage_reset_flag_reg)
		else $error("low-voltage flag not set");
	a_wds_sp_zero: assert property (cls == RSI_CL_WDS
		|=> sp == '0 && program_counter_low == 8'h00)
		else $error("sleep time-out did not clear pointers");
	a_prio_por: assert property (src.por && src.wdt |=> !flags.timeout_flag)
		else $error("power-on lost priority");

	c_por: cover property (src.por);
	c_lvr: cover property (cls == RSI_CL_LVR);
	c_wds: cover property (cls == RSI_CL_WDS);
	c_irq: cover property (irq);

endmodule // rsi_top

// ### rtl/rsi_regs.svh
`ifndef RSI_REGS_SVH
`define RSI_REGS_SVH
// ==========================================================
// Register byte offsets on the APB bus.
`define RSI_OFS_FLAGS 12'h000
`define RSI_OFS_CTRL 12'h004
`define RSI_OFS_EVT 12'h008
`define RSI_OFS_MASK 12'h00c
`define RSI_OFS_PC_LOW 12'h010
`define RSI_OFS_SP 12'h014
`define RSI_OFS_INTEN 12'h018
`define RSI_OFS_TMRC 12'h01c
`define RSI_OFS_TMRCNT 12'h020
`define RSI_OFS_PA 12'h024
`define RSI_OFS_PAC 12'h028
`define RSI_OFS_PB 12'h02c
`define RSI_OFS_PBC 12'h030
`define RSI_OFS_TB_CTRL 12'h034
`define RSI_OFS_WDT 12'h038
// ==========================================================
// Field positions.
`define RSI_BIT_TO 0
`define RSI_BIT_PDF 1
`define RSI_BIT_LV_FLAG 2
`define RSI_EV_POR 0
`define RSI_EV_LVR 1
`define RSI_EV_WDR 2
`define RSI_EV_WDS 3
// ==========================================================
// Default values loaded by a reset.
`define RSI_DEF_ZERO 8'h00
`define RSI_DEF_ONES 8'hff
`define RSI_DEF_PB 7'h7f
`define RSI_DEF_TB_CTRL 8'h37
`endif

// ### rtl/rsi_pkg.sv
package rsi_pkg;
	// Reset class chosen from the coinciding sources.
	typedef enum logic [2:0] {
		RSI_CL_NONE = 3'b000,
		RSI_CL_POR = 3'b001,
		RSI_CL_LVR = 3'b010,
		RSI_CL_WDR = 3'b011,
		RSI_CL_WDS = 3'b100
	} rsi_class_e;
	// Reset sources as seen by the sequencer.
	typedef struct packed {
		logic por; // Power-on detector pulse.
		logic low_voltage_reset; // Low-voltage detector pulse.
		logic wdt; // Watchdog time-out pulse.
		logic sleep; // Core is in sleep or idle mode.
	} rsi_src_s;
	// The two reset flags of the status register.
	typedef struct packed {
		logic powerdown_flag; // Set by a time-out taken while sleeping.
		logic timeout_flag; // Set by any watchdog time-out.
	} rsi_flags_s;
endpackage

// ### test/rsi_src_model.sv
// ==========================================================
// Reset source model: detectors and watchdog beside the core.
module rsi_src_model (
	output rsi_pkg::rsi_src_s src // Reset sources to the sequencer.
	, input wire logic pclk // System clock.
);
	timeunit 1ns;
	timeprecision 1ps;
	import rsi_pkg::*;
	// Sources rest low; sleep only rides along with a time-out pulse.
	initial src = '0;
	// One source pattern for one cycle, launched just after an edge.
	task automatic fire(input rsi_src_s v);
		@(posedge pclk);
		src <= v;
		@(posedge pclk);
		src <= '0;
	endtask
endmodule // rsi_src_model

// ### test/tb_reset_state_initializer.sv
`include "rsi_regs.svh"
// ==========================================================
// Bench for the reset state sequencer.
module tb_reset_state_initializer;
	timeunit 1ns;
	timeprecision 1ps;
	import rsi_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, errv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	rsi_src_s src;
	rsi_flags_s flags;
	logic [7:0] program_counter_low, int_en, tmr_ctrl, tmr_cnt, port_a, port_a_dir;
	logic [7:0] time_base_control, wdt_cnt, c0;
	logic [2:0] sp;
	logic [6:0] port_b, port_b_dir;
	int num_errors = 0; // Mismatches seen.
	int checks = 0; // Comparisons made.
	int cyc = 0; // Cycles run, for the hang guard.
	rsi_src_model i_rsi_src_model (.src(src), .pclk(pclk));
	rsi_top #(.SP_W(3), .WDT_W(8)) i_rsi_top (.pclk(pclk), .presetn(presetn), .src(src),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .flags(flags),
		.program_counter_low(program_counter_low), .sp(sp), .int_en(int_en),
		.tmr_ctrl(tmr_ctrl), .tmr_cnt(tmr_cnt),
		.port_a(port_a), .port_a_dir(port_a_dir), .port_b(port_b), .port_b_dir(port_b_dir),
		.time_base_control(time_base_control), .wdt_cnt(wdt_cnt));
	// ==========================================================
	// Helpers.
	// Clock at 125 MHz.
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Case equality, so an unknown never passes.
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Counts, then the verdict, then the end of the run.
	task automatic summarize();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		// One wait state: the answer stands at the second access edge.
		chk("wait states", n, 32'h2);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rdv, e);
	endtask
	// Fire a source pattern, then look once its edge has landed.
	task automatic hit(input rsi_src_s v);
		i_rsi_src_model.fire(v);
		#1;
	endtask
	// ==========================================================
	// Scenarios.
	// Defaults after power-up, and the watchdog running on its own.
	task automatic t_defaults();
		#1;
		chk("flags", {30'h0, flags}, 32'h0);
		chk("int_en", {24'h0, int_en}, 32'h0);
		chk("timers", {16'h0, tmr_ctrl, tmr_cnt}, 32'h0);
		chk("port a", {16'h0, port_a, port_a_dir}, 32'hffff);
		chk("port b", {18'h0, port_b, port_b_dir}, 32'h3fff);
		chk("sp", {29'h0, sp}, 32'h7);
		chk("time base", {24'h0, time_base_control}, 32'h37);
		c0 = wdt_cnt;
		repeat (5) @(posedge pclk);
		#1;
		chk("wdt count", {24'h0, wdt_cnt}, {24'h0, c0 + 8'h5});
		rchk("pb read", `RSI_OFS_PB, 32'h7f);
		rchk("sp read", `RSI_OFS_SP, 32'h7);
	endtask
	// Sleeping time-out keeps most state but clears counter and stack.
	task automatic t_sleep();
		apb(1'b1, `RSI_OFS_PC_LOW, 32'h5a);
		apb(1'b1, `RSI_OFS_SP, 32'h2);
		apb(1'b1, `RSI_OFS_INTEN, 32'h3c);
		apb(1'b1, `RSI_OFS_PA, 32'h12);
		apb(1'b1, `RSI_OFS_TMRC, 32'h81);
		apb(1'b1, `RSI_OFS_TB_CTRL, 32'h0f);
		hit(4'b0011);
		chk("flags", {30'h0, flags}, 32'h3);
		chk("pc low sp", {21'h0, program_counter_low, sp}, 32'h0);
		chk("time base", {24'h0, time_base_control}, 32'h37);
		chk("kept", {port_a, int_en, tmr_ctrl}, 32'h123c81);
		chk("wdt clr", {24'h0, wdt_cnt}, 32'h0);
	endtask
	// Low-voltage reset: flags held, defaults back, own flag raised.
	task automatic t_lvr();
		hit(4'b0100);
		chk("flags", {30'h0, flags}, 32'h3);
		chk("defaults", {port_a, int_en, 5'h0, sp}, 32'hff0007);
		rchk("lvr flag", `RSI_OFS_CTRL, 32'h4);
		apb(1'b1, `RSI_OFS_CTRL, 32'h0);
		rchk("lvr clear", `RSI_OFS_CTRL, 32'h0);
	endtask
	// Power-on then a running time-out; power-down stays clear.
	task automatic t_run();
		hit(4'b1000);
		chk("flags", {30'h0, flags}, 32'h0);
		apb(1'b1, `RSI_OFS_INTEN, 32'h55);
		hit(4'b0010);
		chk("flags", {30'h0, flags}, 32'h1);
		chk("int_en", {24'h0, int_en}, 32'h0);
		hit(4'b1111);
		chk("por wins", {30'h0, flags}, 32'h0);
		apb(1'b1, `RSI_OFS_SP, 32'h1);
		hit(4'b0111);
		chk("lvr wins", {29'h0, sp}, 32'h7);
	endtask
	// Event bits, mask and write-one-to-clear behind the interrupt.
	task automatic t_irq();
		apb(1'b1, `RSI_OFS_EVT, 32'hf);
		apb(1'b1, `RSI_OFS_MASK, 32'h1);
		hit(4'b0100);
		@(posedge pclk);
		#1;
		chk("irq masked", {31'h0, irq}, 32'h0);
		hit(4'b1000);
		@(posedge pclk);
		#1;
		chk("irq set", {31'h0, irq}, 32'h1);
		rchk("events", `RSI_OFS_EVT, 32'h3);
		apb(1'b1, `RSI_OFS_EVT, 32'h1);
		@(posedge pclk);
		#1;
		chk("irq clr", {31'h0, irq}, 32'h0);
	endtask
	// Unmapped place and read-only flags.
	task automatic t_bus();
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped", {errv, rdv[30:0]}, 32'h80000000);
		apb(1'b1, `RSI_OFS_FLAGS, 32'h3);
		rchk("flags ro", `RSI_OFS_FLAGS, 32'h0);
	endtask
	// ==========================================================
	// Main sequence and hang guard.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_sleep();
		t_lvr();
		t_run();
		t_irq();
		t_bus();
		summarize();
	end
	// The whole run needs well under a thousand cycles.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
endmodule // tb_reset_state_initializer
